// *** sswc_pkg.sv ***
// Package for the synchronous SRAM address capture and write qualification block.
// Assumes one rising-edge clock shared with the controller.
package sswc_pkg;
    localparam int SSWC_LANES = 4;
    localparam int SSWC_LANE_BITS = 8;
    localparam int SSWC_ADDR_W = 19;
    localparam int SSWC_BURST_W = 2;
    localparam logic [1:0] SSWC_BURST_RST = 2'h0;
    localparam logic [1:0] SSWC_BURST_STEP = 2'h1;
    typedef enum logic [1:0] {
        SSWC_IDLE = 2'b00,
        SSWC_BURST = 2'b01
    } sswc_state_t;
endpackage

// *** sswc_lane_qual.sv ***
// Per-lane write qualification: turns the sampled write controls into lane strobes.
// Assumes inputs are already registered on the shared clock.
`timescale 1ns/1ns
module sswc_lane_qual
    import sswc_pkg::*;
#(
    parameter int LANES = SSWC_LANES
) (
    input wire logic [LANES-1:0] lane_write_sel_n_i,
    input wire logic lane_write_enable_n_i,
    input wire logic all_lanes_write_n_i,
    output logic [LANES-1:0] lane_write_o,
    output logic any_write_o
);
    wire global_write = ~all_lanes_write_n_i;
    wire byte_mode = ~lane_write_enable_n_i;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_lane
            assign lane_write_o[g] = global_write | (byte_mode & ~lane_write_sel_n_i[g]);
        end
    endgenerate
    assign any_write_o = |lane_write_o;
endmodule

// *** sswc_capture.sv ***
// Address capture, burst counter start and write qualification of a burst SRAM front end.
// Assumes the controller drives all inputs synchronous to clk_i; the pins are
// still passed through two flops as if they arrived from outside the clock domain.
// Functional notes
// - Capture address on strobe with chip selected
// - Load low address bits into counter
// - Lane select needs byte-write enable
// - Global write writes every lane
// - Processor strobe wins when both low
// - Processor strobe ignored when first select high
// - Lane select covers data and parity
// - Advance low increments counter in burst
`timescale 1ns/1ns
module sswc_capture
    import sswc_pkg::*;
#(
    parameter int ADDR_W = SSWC_ADDR_W,
    parameter int LANES = SSWC_LANES,
    parameter int LANE_W = SSWC_LANE_BITS + 1
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic [ADDR_W-1:0] addr_i,
    input wire logic processor_addr_strobe_n_i,
    input wire logic controller_addr_strobe_n_i,
    input wire logic burst_advance_n_i,
    input wire logic chip_sel_first_n_i,
    input wire logic chip_sel_second_i,
    input wire logic chip_sel_third_n_i,
    input wire logic [LANES-1:0] lane_write_sel_n_i,
    input wire logic lane_write_enable_n_i,
    input wire logic all_lanes_write_n_i,
    input wire logic [LANES*LANE_W-1:0] wr_data_i,
    output logic [ADDR_W-1:0] cap_addr_o,
    output logic [SSWC_BURST_W-1:0] burst_pos_o,
    output logic capture_o,
    output logic proc_capture_o,
    output logic burst_active_o,
    output logic [LANES-1:0] lane_write_o,
    output logic write_o,
    output logic read_o,
    output logic [LANES*LANE_W-1:0] wr_data_o,
    output logic [LANES*LANE_W-1:0] wr_mask_o
);
    localparam int CW = 9 + LANES;
    localparam int VW = ADDR_W + LANES * LANE_W;
    logic [CW-1:0] ctl_s1;
    logic [CW-1:0] ctl_s2;
    logic [VW-1:0] val_s1;
    logic [VW-1:0] val_s2;
    wire [CW-1:0] ctl_in = {processor_addr_strobe_n_i, controller_addr_strobe_n_i,
        burst_advance_n_i, chip_sel_first_n_i, chip_sel_second_i, chip_sel_third_n_i,
        lane_write_enable_n_i, all_lanes_write_n_i, 1'b0, lane_write_sel_n_i};

    // Two-flop synchronisers; the first stage feeds only the second
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ctl_s1 <= {CW{1'b1}};
            ctl_s2 <= {CW{1'b1}};
            val_s1 <= '0;
            val_s2 <= '0;
        end else begin
            ctl_s1 <= ctl_in;
            ctl_s2 <= ctl_s1;
            val_s1 <= {addr_i, wr_data_i};
            val_s2 <= val_s1;
        end
    end

    wire s_proc_stb_n = ctl_s2[CW-1];
    wire s_ctrl_stb_n = ctl_s2[CW-2];
    wire s_advance_n = ctl_s2[CW-3];
    wire s_sel_first_n = ctl_s2[CW-4];
    wire s_sel_second = ctl_s2[CW-5];
    wire s_sel_third_n = ctl_s2[CW-6];
    wire s_lane_en_n = ctl_s2[CW-7];
    wire s_all_write_n = ctl_s2[CW-8];
    wire [LANES-1:0] s_bw_n = ctl_s2[LANES-1:0];
    wire [ADDR_W-1:0] s_addr = val_s2[VW-1 -: ADDR_W];
    wire [LANES*LANE_W-1:0] s_data = val_s2[LANES*LANE_W-1:0];

    wire chip_sel = ~s_sel_first_n & s_sel_second & ~s_sel_third_n;
    wire proc_take = ~s_proc_stb_n & ~s_sel_first_n;
    wire proc_cap = proc_take & chip_sel;
    wire ctrl_cap = ~proc_take & ~s_ctrl_stb_n & chip_sel;
    wire cap = proc_cap | ctrl_cap;

    sswc_state_t state;
    sswc_state_t next_state;
    logic [SSWC_BURST_W-1:0] next_burst;
    assign next_state = cap ? SSWC_BURST : state;
    assign next_burst = cap ? s_addr[SSWC_BURST_W-1:0] :
        ((state == SSWC_BURST && !s_advance_n) ? burst_pos_o + SSWC_BURST_STEP : burst_pos_o);

    logic [LANES-1:0] qual;
    logic qual_any;
    sswc_lane_qual #(.LANES(LANES)) u_qual (
        .lane_write_sel_n_i(s_bw_n),
        .lane_write_enable_n_i(s_lane_en_n),
        .all_lanes_write_n_i(s_all_write_n),
        .lane_write_o(qual),
        .any_write_o(qual_any)
    );

    logic [LANES*LANE_W-1:0] next_mask;
    genvar g;
    generate
        for (g = 0; g < LANES; g++) begin : g_mask
            assign next_mask[g*LANE_W +: LANE_W] = {LANE_W{qual[g]}};
        end
    endgenerate

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            state <= SSWC_IDLE;
            burst_pos_o <= SSWC_BURST_RST;
            cap_addr_o <= '0;
            capture_o <= 1'b0;
            proc_capture_o <= 1'b0;
        end else begin
            state <= next_state;
            burst_pos_o <= next_burst;
            capture_o <= cap;
            proc_capture_o <= proc_cap;
            if (cap) begin
                cap_addr_o <= s_addr;
            end
        end
    end

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            lane_write_o <= '0;
            write_o <= 1'b0;
            read_o <= 1'b0;
            wr_data_o <= '0;
            wr_mask_o <= '0;
        end else begin
            lane_write_o <= qual;
            write_o <= qual_any;
            read_o <= ~qual_any;
            wr_data_o <= s_data;
            wr_mask_o <= next_mask;
        end
    end

    assign burst_active_o = (state == SSWC_BURST);

    // Assertions
    a_capture_cond: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        capture_o |-> $past(chip_sel) && ($past(~s_proc_stb_n) || $past(~s_ctrl_stb_n)))
        else $error("capture without strobe and select");
    a_capture_addr: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cap |=> cap_addr_o == $past(s_addr))
        else $error("address not captured");
    a_addr_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !cap |=> $stable(cap_addr_o))
        else $error("address changed without capture");
    a_burst_load: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        cap |=> burst_pos_o == $past(s_addr[SSWC_BURST_W-1:0]))
        else $error("burst start wrong");
    a_byte_qual: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_all_write_n && s_lane_en_n) |=> lane_write_o == '0)
        else $error("lane write without enable");
    a_byte_lanes: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_all_write_n && !s_lane_en_n) |=> lane_write_o == ~$past(s_bw_n))
        else $error("byte write lanes wrong");
    a_global_all: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !s_all_write_n |=> &lane_write_o)
        else $error("global write missed lanes");
    a_global_write: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        !s_all_write_n |=> write_o && !read_o)
        else $error("global write not flagged");
    a_proc_wins: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!s_proc_stb_n && !s_ctrl_stb_n && chip_sel) |=> proc_capture_o)
        else $error("processor strobe lost");
    a_ctrl_only: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (s_proc_stb_n && !s_ctrl_stb_n && chip_sel) |=> capture_o && !proc_capture_o)
        else $error("controller capture wrong");
    a_first_sel_ignore: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        s_sel_first_n |=> !capture_o)
        else $error("capture while deselected");
    a_parity_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        wr_mask_o[LANE_W-1] == lane_write_o[0])
        else $error("parity mask mismatch");
    // Every lane, parity bit included, follows its own strobe
    generate
        for (g = 0; g < LANES; g++) begin : g_mask_chk
            a_lane_mask: assert property (@(posedge clk_i) disable iff (!arst_n_i)
                wr_mask_o[g*LANE_W +: LANE_W] == {LANE_W{lane_write_o[g]}})
                else $error("lane mask mismatch");
        end
    endgenerate
    a_burst_adv: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!cap && burst_active_o && !s_advance_n) |=>
        burst_pos_o == $past(burst_pos_o) + SSWC_BURST_STEP)
        else $error("burst did not advance");
    a_burst_hold: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        (!cap && (!burst_active_o || s_advance_n)) |=> $stable(burst_pos_o))
        else $error("burst moved without advance");
    a_read_idle: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        read_o |-> lane_write_o == '0 && !write_o)
        else $error("read with write");
    a_write_flag: assert property (@(posedge clk_i) disable iff (!arst_n_i)
        write_o == (|lane_write_o))
        else $error("write flag disagrees with lanes");
    c_proc_cap: cover property (@(posedge clk_i) disable iff (!arst_n_i) proc_capture_o);
    c_ctrl_cap: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        capture_o && !proc_capture_o);
    c_global: cover property (@(posedge clk_i) disable iff (!arst_n_i) &lane_write_o);
    c_byte_write: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        write_o && !(&lane_write_o));
    c_advance: cover property (@(posedge clk_i) disable iff (!arst_n_i)
        burst_active_o && !s_advance_n);
endmodule

// *** sswc_ctrl_model.sv ***
// Controller model: drives the SRAM front-end pins at each falling clock edge.
// Assumes the bench picks a corner mode; other cycles are random from a fixed seed.
`timescale 1ns/1ns
module sswc_ctrl_model (
    input wire logic clk_i,
    input wire logic [2:0] mode_i,
    output logic [18:0] addr_o,
    output logic [35:0] data_o,
    output logic ps_n_o,
    output logic cs_n_o,
    output logic advance_n_o,
    output logic sel_first_n_o,
    output logic sel_second_o,
    output logic sel_third_n_o,
    output logic [3:0] sel_n_o,
    output logic lane_en_n_o,
    output logic all_write_n_o
);
    int seed = 2466;
    logic [31:0] r;
    initial begin
        addr_o = '0;
        data_o = '0;
        sel_n_o = 4'hf;
        {ps_n_o, cs_n_o, advance_n_o, sel_first_n_o, sel_second_o, sel_third_n_o,
            lane_en_n_o, all_write_n_o} = 8'hf7;
    end
    always @(negedge clk_i) begin
        r = $random(seed);
        addr_o = 19'($random(seed));
        data_o = {r[3:0], 32'($random(seed))};
        {ps_n_o, cs_n_o, advance_n_o, all_write_n_o, sel_n_o} = r[15:8];
        // Selects biased active so captures are frequent
        sel_first_n_o = r[4] & r[5];
        sel_second_o = r[6] | r[7];
        sel_third_n_o = r[4] & r[6];
        // byte write intent drives enable low
        lane_en_n_o = !r[16];
        // Corners: both strobes, first select high, global write, lane selects without enable, advance, single strobes
        case (mode_i)
            3'h1: {ps_n_o, cs_n_o, sel_first_n_o, sel_second_o, sel_third_n_o} = 5'h02;
            3'h2: {ps_n_o, cs_n_o, sel_first_n_o, sel_second_o, sel_third_n_o} = 5'h06;
            3'h3: {all_write_n_o, lane_en_n_o} = 2'h1;
            3'h4: {all_write_n_o, lane_en_n_o, sel_n_o} = 6'h30;
            3'h5: {ps_n_o, cs_n_o, advance_n_o} = 3'h6;
            3'h6: {ps_n_o, cs_n_o, sel_first_n_o, sel_second_o, sel_third_n_o} = 5'h0a;
            3'h7: {ps_n_o, cs_n_o, sel_first_n_o, sel_second_o, sel_third_n_o} = 5'h12;
            default: ;
        endcase
    end
endmodule

// *** sswc_capture_tb.sv ***
// Self-checking bench for the address capture and write qualification block.
// Assumes outputs follow the inputs sampled two edges earlier than the current edge.
`timescale 1ns/1ns
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module sswc_capture_tb;
    import sswc_pkg::*;
    logic clk = 0, arst_n = 0, ps_n, cs_n, step_n, sf_n, ss, st_n, en_n, all_n;
    logic [18:0] addr, cap_addr, e_addr;
    logic [35:0] data, wr_data, wr_mask;
    logic [3:0] sel_n, lw, l;
    logic [1:0] pos, e_pos, c;
    logic [2:0] mode;
    logic cap, pcap, act, wr, rd, e_act;
    logic [66:0] pin, p[3];
    int cnt, k, n_mismatch, checks_done;
    always #50 clk = ~clk;
    assign pin = {addr, ps_n, cs_n, step_n, sf_n, ss, st_n, sel_n, en_n, all_n, data};
    assign mode = (k[5:4] == 2'h0) ? k[2:0] : 3'h0;
    sswc_ctrl_model u_ctrl (.clk_i(clk), .mode_i(mode), .addr_o(addr), .data_o(data),
        .ps_n_o(ps_n), .cs_n_o(cs_n), .advance_n_o(step_n), .sel_first_n_o(sf_n),
        .sel_second_o(ss), .sel_third_n_o(st_n), .sel_n_o(sel_n), .lane_en_n_o(en_n),
        .all_write_n_o(all_n));
    sswc_capture u_dut (.clk_i(clk), .arst_n_i(arst_n), .addr_i(addr),
        .processor_addr_strobe_n_i(ps_n), .controller_addr_strobe_n_i(cs_n),
        .burst_advance_n_i(step_n), .chip_sel_first_n_i(sf_n), .chip_sel_second_i(ss),
        .chip_sel_third_n_i(st_n), .lane_write_sel_n_i(sel_n),
        .lane_write_enable_n_i(en_n), .all_lanes_write_n_i(all_n), .wr_data_i(data),
        .cap_addr_o(cap_addr), .burst_pos_o(pos), .capture_o(cap), .proc_capture_o(pcap),
        .burst_active_o(act), .lane_write_o(lw), .write_o(wr), .read_o(rd),
        .wr_data_o(wr_data), .wr_mask_o(wr_mask));
    function automatic logic [3:0] lanes(input logic [66:0] v);
        if (!v[36]) return 4'hf;
        return v[37] ? 4'h0 : ~v[41:38];
    endfunction
    function automatic logic [1:0] capt(input logic [66:0] v);
        logic s;
        s = !v[44] && v[43] && !v[42];
        return {s && !(v[47] && v[46]), s && !v[47]};
    endfunction
    function automatic logic [35:0] mask(input logic [3:0] m);
        for (int g = 0; g < 4; g++) mask[g*9+:9] = {9{m[g]}};
    endfunction
    always @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            {e_addr, e_pos, e_act, cnt} = '0;
        end else begin
            {p[2], p[1], p[0]} = {p[1], p[0], pin};
            k++;
            if (cnt < 3) cnt++;
            c = capt(p[2]);
            if (cnt == 3 && c[1]) begin
                {e_addr, e_pos, e_act} = {p[2][66:48], p[2][49:48], 1'b1};
            end else if (cnt == 3 && e_act && !p[2][45]) begin
                e_pos++;
            end
        end
    end
    task automatic report_and_stop();
        if (n_mismatch == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (20) @(negedge clk);
        arst_n = 1;
        for (int i = 0; i < 3000; i++) begin
            @(negedge clk);
            if (cnt == 3) begin
                l = lanes(p[2]);
                `CHK(cap, c[1])
                `CHK(pcap, c[0])
                `CHK(cap_addr, e_addr)
                `CHK(pos, e_pos)
                `CHK(lw, l)
                `CHK({wr, rd}, {|l, ~|l})
                `CHK({wr_mask, wr_data}, {mask(l), p[2][35:0]})
                `CHK(act, e_act)
            end
            // Mid-run reset: outputs clear at once, tracking restarts with it
            if (i == 1500) begin
                arst_n = 0;
                @(negedge clk);
                `CHK({cap_addr, pos, act, lw, wr, rd, cap, pcap}, 30'h0)
                arst_n = 1;
            end
        end
        report_and_stop();
    end
endmodule
